/* verilog/out_card.sv */
// Twelve-bit gated parallel output card with AXI4-Lite register access
//
// Summary of operation
// - Twelve output bits, each holding the last value written to it.
// - Transfers use a gate strobe out, acknowledged by a flag coming back.
// - Timing mode off: transfer finishes alone, no acknowledge awaited.
// - Timing mode on: completion flag held, trailing edge returned at finish.
// - In IEEE-488 link mode a timing-mode completion raises service request.
// - Completion flag line driven only while transfer enable is set.
// - Addressed data word reaches output lines at once while system enable is set, even without transfer enable.
// - Gate withheld until a control word with transfer enable arrives.
// - Timing mode: flag pending while flag input idle, done after pulse.
// - Standard: set bit drives low; inverted option: set bit drives high.
// - Open-collector variant: twelve latched open-collector outputs.
// - Open-collector variant ignores the system enable bit.
// - Standard open collector: set bit turns on; inverted: set bit off.
`timescale 1ns/1ps
`default_nettype none
module out_card (
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        AWVALID_IN,
  output logic             AWREADY_OUT,
  input  wire logic [7:0]  AWADDR_IN,
  input  wire logic        WVALID_IN,
  output logic             WREADY_OUT,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic [3:0]  WSTRB_IN,
  output logic             BVALID_OUT,
  input  wire logic        BREADY_IN,
  output logic [1:0]       BRESP_OUT,
  input  wire logic        ARVALID_IN,
  output logic             ARREADY_OUT,
  input  wire logic [7:0]  ARADDR_IN,
  output logic             RVALID_OUT,
  input  wire logic        RREADY_IN,
  output logic [31:0]      RDATA_OUT,
  output logic [1:0]       RRESP_OUT,
  output logic [11:0]      DATA_LINE_OUT,
  input  wire logic [11:0] OC_LINE_IN,
  output logic [11:0]      OC_LINE_OUT,
  output logic [11:0]      OC_LINE_OE_N_OUT,
  output logic             GATE_OUT,
  input  wire logic        FLAG_IN,
  output logic             TRANSFER_COMPLETE_FLAG_OUT,
  output logic             TRANSFER_COMPLETE_FLAG_OE_N_OUT,
  output logic             SERVICE_REQUEST_OUT,
  output logic             IRQ_OUT
);
  function automatic logic mapped(input logic [7:0] a);
    if (a == out_card_pkg::OFS_CONTROL) begin
      return 1'b1;
    end else if (a == out_card_pkg::OFS_DATA) begin
      return 1'b1;
    end else if (a == out_card_pkg::OFS_CONFIG) begin
      return 1'b1;
    end else if (a == out_card_pkg::OFS_STATUS) begin
      return 1'b1;
    end else if (a == out_card_pkg::OFS_INT_STATUS) begin
      return 1'b1;
    end else if (a == out_card_pkg::OFS_INT_MASK) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Bus state
  logic        aw_full, next_aw_full;
  logic [7:0]  aw_addr, next_aw_addr;
  logic        w_full, next_w_full;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        awready, next_awready;
  logic        wready, next_wready;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        arready, next_arready;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;
  // Card state
  out_card_pkg::card_state_e state, next_state;
  logic [3:0]  cnt, next_cnt;
  logic [2:0]  en, next_en;
  logic [11:0] data_word, next_data_word;
  logic [6:0]  cfg, next_cfg;
  logic        int_status, next_int_status;
  logic        int_mask, next_int_mask;
  logic        srq, next_srq;
  logic        transfer_complete_flag, next_ctf;
  logic        ctf_oe_n, next_ctf_oe_n;
  logic        gate, next_gate;
  logic [11:0] lines, next_lines;
  logic [11:0] oc_oe_n, next_oc_oe_n;
  logic [11:0] oc_out;
  logic        irq, next_irq;
  // Write decode
  logic        wr_fire, ctl_wr, data_wr, done_evt;
  logic [31:0] wv, status_w;

  assign wr_fire = aw_full && w_full && !bvalid;
  assign wv      = merge(out_card_pkg::WORD_RESET, w_data, w_strb);
  assign ctl_wr  = wr_fire && aw_addr == out_card_pkg::OFS_CONTROL;
  assign data_wr = wr_fire && aw_addr == out_card_pkg::OFS_DATA &&
    wv[out_card_pkg::DATA_SLOT_LSB +: out_card_pkg::SLOT_W] ==
    cfg[out_card_pkg::CFG_SLOT_LSB +: out_card_pkg::SLOT_W];
  assign status_w = {16'h0000, OC_LINE_IN, srq, FLAG_IN, transfer_complete_flag, gate};

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    // Address and data are taken in either order
    if (AWVALID_IN && awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = AWADDR_IN;
    end
    if (WVALID_IN && wready) begin
      next_w_full = 1'b1;
      next_w_data = WDATA_IN;
      next_w_strb = WSTRB_IN;
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? out_card_pkg::RESP_OKAY :
                                       out_card_pkg::RESP_SLVERR;
    end else if (bvalid && BREADY_IN) begin
      next_bvalid = 1'b0;
    end
    if (ARVALID_IN && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(ARADDR_IN) ? out_card_pkg::RESP_OKAY :
                                        out_card_pkg::RESP_SLVERR;
      if (ARADDR_IN == out_card_pkg::OFS_CONTROL) begin
        next_rdata = {29'h0000_0000, en};
      end else if (ARADDR_IN == out_card_pkg::OFS_DATA) begin
        next_rdata = {20'h0_0000, data_word};
      end else if (ARADDR_IN == out_card_pkg::OFS_CONFIG) begin
        next_rdata = {25'h000_0000, cfg};
      end else if (ARADDR_IN == out_card_pkg::OFS_STATUS) begin
        next_rdata = status_w;
      end else if (ARADDR_IN == out_card_pkg::OFS_INT_STATUS) begin
        next_rdata = {31'h0000_0000, int_status};
      end else if (ARADDR_IN == out_card_pkg::OFS_INT_MASK) begin
        next_rdata = {31'h0000_0000, int_mask};
      end else begin
        next_rdata = out_card_pkg::WORD_RESET;
      end
    end else if (rvalid && RREADY_IN) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full  <= 1'b0;
      w_data  <= out_card_pkg::WORD_RESET;
      w_strb  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= out_card_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= out_card_pkg::WORD_RESET;
      rresp   <= out_card_pkg::RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full  <= next_w_full;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_en         = en;
    next_data_word  = data_word;
    next_cfg        = cfg;
    next_int_status = int_status;
    next_int_mask   = int_mask;
    next_srq        = srq;
    done_evt        = 1'b0;
    if (state == out_card_pkg::ST_GATE) begin
      if (en[out_card_pkg::TME_BIT]) begin
        if (FLAG_IN) begin
          next_state = out_card_pkg::ST_IDLE;
          done_evt   = 1'b1;
        end
      end else if (cnt == 4'(out_card_pkg::GATE_CYCLES - 1)) begin
        next_state = out_card_pkg::ST_IDLE;
      end else begin
        next_cnt = cnt + 4'h1;
      end
    end
    if (ctl_wr) begin
      next_en = wv[out_card_pkg::EN_W-1:0];
      if (!wv[out_card_pkg::TME_BIT]) begin
        next_srq = 1'b0;
      end
      if (state == out_card_pkg::ST_LOADED &&
          wv[out_card_pkg::DTE_BIT]) begin
        next_state = out_card_pkg::ST_GATE;
        next_cnt   = 4'h0;
      end
    end
    if (data_wr) begin
      next_data_word = wv[out_card_pkg::LINES-1:0];
      next_cnt       = 4'h0;
      next_state     = en[out_card_pkg::DTE_BIT] ?
                       out_card_pkg::ST_GATE : out_card_pkg::ST_LOADED;
    end
    if (wr_fire && aw_addr == out_card_pkg::OFS_CONFIG) begin
      next_cfg = wv[out_card_pkg::CFG_W-1:0];
    end
    if (wr_fire && aw_addr == out_card_pkg::OFS_INT_MASK) begin
      next_int_mask = wv[out_card_pkg::INT_DONE_BIT];
    end
    // Clear first so a completion in the same cycle is kept
    if (wr_fire && aw_addr == out_card_pkg::OFS_INT_STATUS &&
        wv[out_card_pkg::INT_DONE_BIT]) begin
      next_int_status = 1'b0;
    end
    if (done_evt) begin
      next_int_status = 1'b1;
      if (cfg[out_card_pkg::CFG_IEEE_BIT]) begin
        next_srq = 1'b1;
      end
    end
    next_gate     = next_state == out_card_pkg::ST_GATE;
    next_ctf      = next_gate && next_en[out_card_pkg::TME_BIT];
    next_ctf_oe_n = !next_en[out_card_pkg::DTE_BIT];
    // Disabled lines rest at the level of a cleared bit
    if (!next_en[out_card_pkg::SYE_BIT]) begin
      next_lines = next_cfg[out_card_pkg::CFG_INVERT_BIT] ?
                   12'h000 : out_card_pkg::LINES_ONES;
    end else if (next_cfg[out_card_pkg::CFG_INVERT_BIT]) begin
      next_lines = next_data_word;
    end else begin
      next_lines = ~next_data_word;
    end
    // Open collector ignores the system enable
    if (!next_cfg[out_card_pkg::CFG_OC_BIT]) begin
      next_oc_oe_n = out_card_pkg::LINES_ONES;
    end else if (next_cfg[out_card_pkg::CFG_INVERT_BIT]) begin
      next_oc_oe_n = next_data_word;
    end else begin
      next_oc_oe_n = ~next_data_word;
    end
    next_irq = next_int_status && next_int_mask;
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state      <= out_card_pkg::ST_IDLE;
      cnt        <= 4'h0;
      en         <= 3'h0;
      data_word  <= 12'h000;
      cfg        <= 7'h00;
      int_status <= 1'b0;
      int_mask   <= 1'b0;
      srq        <= 1'b0;
      transfer_complete_flag        <= 1'b0;
      ctf_oe_n   <= 1'b1;
      gate       <= 1'b0;
      lines      <= out_card_pkg::LINES_ONES;
      oc_oe_n    <= out_card_pkg::LINES_ONES;
      oc_out     <= 12'h000;
      irq        <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      en         <= next_en;
      data_word  <= next_data_word;
      cfg        <= next_cfg;
      int_status <= next_int_status;
      int_mask   <= next_int_mask;
      srq        <= next_srq;
      transfer_complete_flag        <= next_ctf;
      ctf_oe_n   <= next_ctf_oe_n;
      gate       <= next_gate;
      lines      <= next_lines;
      oc_oe_n    <= next_oc_oe_n;
      oc_out     <= 12'h000;
      irq        <= next_irq;
    end
  end

  assign AWREADY_OUT = awready;
  assign WREADY_OUT  = wready;
  assign BVALID_OUT  = bvalid;
  assign BRESP_OUT   = bresp;
  assign ARREADY_OUT = arready;
  assign RVALID_OUT  = rvalid;
  assign RDATA_OUT   = rdata;
  assign RRESP_OUT   = rresp;
  assign DATA_LINE_OUT    = lines;
  assign OC_LINE_OUT      = oc_out;
  assign OC_LINE_OE_N_OUT = oc_oe_n;
  assign GATE_OUT         = gate;
  assign TRANSFER_COMPLETE_FLAG_OUT      = transfer_complete_flag;
  assign TRANSFER_COMPLETE_FLAG_OE_N_OUT = ctf_oe_n;
  assign SERVICE_REQUEST_OUT             = srq;
  assign IRQ_OUT                         = irq;

  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  sequence s_auto_start;
    data_wr && en[out_card_pkg::DTE_BIT] && !en[out_card_pkg::TME_BIT];
  endsequence
  sequence s_gate_pulse;
    GATE_OUT [*5] ##1 !GATE_OUT;
  endsequence
  sequence s_ack;
    GATE_OUT && en[out_card_pkg::TME_BIT] && FLAG_IN && !ctl_wr && !data_wr;
  endsequence

  a_auto_gate_width: assert property (
    s_auto_start ##0 !ctl_wr |=> s_gate_pulse)
    else $error("automatic gate width wrong");
  a_gate_withheld: assert property (
    data_wr && !en[out_card_pkg::DTE_BIT] ##1 !ctl_wr && !data_wr
    |=> !GATE_OUT)
    else $error("gate raised without transfer enable");
  a_flag_pending: assert property (
    GATE_OUT && en[out_card_pkg::TME_BIT] && !FLAG_IN && !ctl_wr &&
    !data_wr |=> GATE_OUT && TRANSFER_COMPLETE_FLAG_OUT)
    else $error("completion flag dropped before acknowledge");
  a_flag_trailing: assert property (
    s_ack |=> $fell(TRANSFER_COMPLETE_FLAG_OUT) && int_status)
    else $error("no trailing edge after acknowledge");
  a_service_request: assert property (
    s_ack ##0 cfg[out_card_pkg::CFG_IEEE_BIT] |=> SERVICE_REQUEST_OUT)
    else $error("service request not raised");
  a_flag_drive: assert property (
    en[out_card_pkg::DTE_BIT] == !TRANSFER_COMPLETE_FLAG_OE_N_OUT)
    else $error("completion flag driven without transfer enable");
  a_data_lines: assert property (
    data_wr && en[out_card_pkg::SYE_BIT] && !ctl_wr |=>
    DATA_LINE_OUT == (cfg[out_card_pkg::CFG_INVERT_BIT] ?
                      $past(wv[11:0]) : ~$past(wv[11:0])))
    else $error("data word not on the lines");
  a_oc_ignores_sye: assert property (
    cfg[out_card_pkg::CFG_OC_BIT] && !cfg[out_card_pkg::CFG_INVERT_BIT]
    |-> OC_LINE_OE_N_OUT == ~data_word)
    else $error("open collector output wrong");
  a_irq_level: assert property (
    IRQ_OUT == $past(next_int_status && next_int_mask))
    else $error("interrupt level wrong");
  a_write_answer: assert property (
    wr_fire |=> BVALID_OUT && !AWREADY_OUT && !WREADY_OUT)
    else $error("write not answered");
endmodule
`default_nettype wire

/* pkg/out_card_pkg.sv */
// Constants and types for the twelve-bit gated parallel output card
package out_card_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          LINES          = 12;
  localparam int          SLOT_W         = 4;
  localparam int          EN_W           = 3;
  localparam int          CFG_W          = 7;
  localparam int          CNT_W          = 4;
  // Register byte offsets
  localparam logic [7:0]  OFS_CONTROL    = 8'h00;
  localparam logic [7:0]  OFS_DATA       = 8'h04;
  localparam logic [7:0]  OFS_CONFIG     = 8'h08;
  localparam logic [7:0]  OFS_STATUS     = 8'h0C;
  localparam logic [7:0]  OFS_INT_STATUS = 8'h10;
  localparam logic [7:0]  OFS_INT_MASK   = 8'h14;
  // Control word enable bits
  localparam int          SYE_BIT        = 0;
  localparam int          DTE_BIT        = 1;
  localparam int          TME_BIT        = 2;
  // Data word slot field
  localparam int          DATA_SLOT_LSB  = 16;
  // Configuration fields
  localparam int          CFG_SLOT_LSB   = 0;
  localparam int          CFG_INVERT_BIT = 4;
  localparam int          CFG_OC_BIT     = 5;
  localparam int          CFG_IEEE_BIT   = 6;
  // Status fields
  localparam int          STAT_GATE_BIT  = 0;
  localparam int          STAT_PEND_BIT  = 1;
  localparam int          STAT_FLAG_BIT  = 2;
  localparam int          STAT_SRQ_BIT   = 3;
  localparam int          STAT_LINE_LSB  = 4;
  localparam int          INT_DONE_BIT   = 0;
  // Reset values
  localparam logic [31:0] WORD_RESET     = 32'h0000_0000;
  localparam logic [11:0] LINES_ONES     = 12'hFFF;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // Automatic-mode gate width
  localparam int          GATE_TIME_NS   = 100;
  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          GATE_CYCLES    =
    (GATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {ST_IDLE, ST_LOADED, ST_GATE} card_state_e;
endpackage

/* test/flag_responder.sv */
// External device model that answers the card's gate with a flag
`timescale 1ns/1ps
`default_nettype none
module flag_responder #(
  parameter int ACK_DELAY = 4
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        gate_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic [11:0] oc_oe_n_in,
  output logic             flag_out,
  output logic [11:0]      oc_wire_out
);
  logic [7:0] gate_cycles;
  logic       pulse;
  // Mode 0 jumper, mode 1 late one-cycle ack, mode 2 device never answers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gate_cycles <= 8'h00;
      pulse       <= 1'b0;
    end else begin
      // Count only in ack mode, so a gate raised while silent still gets one
      gate_cycles <= (gate_in && mode_in == 2'h1) ?
                     gate_cycles + 8'h01 : 8'h00;
      pulse       <= gate_in && (gate_cycles == 8'(ACK_DELAY - 1));
    end
  end
  // Jumper mode is combinational, as a wire from gate to flag would be
  always_comb begin
    if (mode_in == 2'h0) begin
      flag_out = gate_in;
    end else begin
      flag_out = (mode_in == 2'h1) && pulse;
    end
  end
  // Pull-up on every line: a transistor that is off reads high
  assign oc_wire_out = oc_oe_n_in;
endmodule
`default_nettype wire

/* test/out_card_tb.sv */
// Self-checking bench for the gated parallel output card
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module out_card_tb;
  localparam logic [3:0]  SLOT = 4'h3;
  localparam logic [31:0] SYSTEM_OUTPUT_ENABLE  = 32'h0000_0001 << out_card_pkg::SYE_BIT;
  localparam logic [31:0] DATA_TRANSFER_ENABLE  = 32'h0000_0001 << out_card_pkg::DTE_BIT;
  localparam logic [31:0] TIMING_MODE_ENABLE  = 32'h0000_0001 << out_card_pkg::TME_BIT;
  localparam logic [1:0]  OK   = out_card_pkg::RESP_OKAY;
  logic        ref_clk = 1'b0, reset_n = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [1:0]  mode = 2'h0;
  logic        awready, wready, bvalid, arready, rvalid, gate, flag;
  logic        cflag, cflag_oe_n, srq, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] data_line, oc_wire, oc_line, oc_oe_n;
  int          fail_count = 0, compares = 0, run = 0, gate_len = 0, n;
  out_card dut (.REF_CLK_IN(ref_clk), .RESET_N_IN(reset_n),
    .AWVALID_IN(awvalid), .AWREADY_OUT(awready), .AWADDR_IN(awaddr),
    .WVALID_IN(wvalid), .WREADY_OUT(wready), .WDATA_IN(wdata),
    .WSTRB_IN(4'hF), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .BRESP_OUT(bresp), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .ARADDR_IN(araddr), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .DATA_LINE_OUT(data_line),
    .OC_LINE_IN(oc_wire), .OC_LINE_OUT(oc_line),
    .OC_LINE_OE_N_OUT(oc_oe_n), .GATE_OUT(gate), .FLAG_IN(flag),
    .TRANSFER_COMPLETE_FLAG_OUT(cflag),
    .TRANSFER_COMPLETE_FLAG_OE_N_OUT(cflag_oe_n),
    .SERVICE_REQUEST_OUT(srq), .IRQ_OUT(irq));
  flag_responder dev (.clk_in(ref_clk), .rst_n_in(reset_n), .gate_in(gate),
    .mode_in(mode), .oc_oe_n_in(oc_oe_n), .flag_out(flag),
    .oc_wire_out(oc_wire));
  always #10 ref_clk = ~ref_clk;
  // Gate width in clock edges, latched when the gate drops
  always @(posedge ref_clk) begin
    if (gate) begin
      run <= run + 1;
    end else if (run != 0) begin
      gate_len <= run;
      run      <= 0;
    end
  end
  function automatic logic [31:0] dw(input logic [3:0]  s,
                                     input logic [11:0] b);
    return ({28'h0, s} << out_card_pkg::DATA_SLOT_LSB) | {20'h0, b};
  endfunction
  function automatic logic [31:0] cfg(input logic [2:0] f);
    return ({29'h0, f} << out_card_pkg::CFG_INVERT_BIT) | {28'h0, SLOT};
  endfunction
  // Settle k edges, then look after their updates have landed
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(posedge ref_clk); while (!bvalid);
    `CHECK(bresp, er)
    bready <= 1'b0;
    #1;
  endtask
  // Data is compared only when an OKAY answer is expected
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge ref_clk); while (!(arvalid && arready));
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    `CHECK(rresp, er)
    if (er === OK) `CHECK(rdata, ed)
    rready <= 1'b0;
    #1;
  endtask
  task automatic finish_test;
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    finish_test;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    step(1);
    `CHECK(data_line, out_card_pkg::LINES_ONES)
    `CHECK(oc_oe_n, 12'hFFF)
    `CHECK(gate, 1'b0)
    wr(out_card_pkg::OFS_CONFIG, cfg(3'h0), OK);
    wr(out_card_pkg::OFS_CONTROL, SYSTEM_OUTPUT_ENABLE | DATA_TRANSFER_ENABLE, OK);
    wr(out_card_pkg::OFS_DATA, dw(SLOT, 12'h001), OK);
    step(2);
    `CHECK(data_line, 12'hFFE)
    `CHECK(gate, 1'b1)
    for (n = 0; n < 30 && gate; n++) step(1);
    step(1);
    `CHECK(gate_len, out_card_pkg::GATE_CYCLES)
    `CHECK(cflag, 1'b0)
    rd(out_card_pkg::OFS_INT_STATUS, 32'h0000_0000, OK);
    wr(out_card_pkg::OFS_DATA, dw(4'h4, 12'h0F0), OK);
    step(2);
    `CHECK(data_line, 12'hFFE)
    rd(out_card_pkg::OFS_DATA, 32'h0000_0001, OK);
    // Deferred gate: load with transfer enable off, gate on later
    wr(out_card_pkg::OFS_CONTROL, SYSTEM_OUTPUT_ENABLE, OK);
    wr(out_card_pkg::OFS_DATA, dw(SLOT, 12'h800), OK);
    step(10);
    `CHECK(data_line, 12'h7FF)
    `CHECK(gate, 1'b0)
    `CHECK(cflag_oe_n, 1'b1)
    wr(out_card_pkg::OFS_CONTROL, SYSTEM_OUTPUT_ENABLE | DATA_TRANSFER_ENABLE, OK);
    for (n = 0; n < 20 && !gate; n++) step(1);
    `CHECK(gate, 1'b1)
    for (n = 0; n < 30 && gate; n++) step(1);
    // Timing mode with a silent device, then a late one-cycle ack
    mode <= 2'h2;
    wr(out_card_pkg::OFS_INT_MASK, 32'h0000_0001, OK);
    wr(out_card_pkg::OFS_CONTROL, SYSTEM_OUTPUT_ENABLE | DATA_TRANSFER_ENABLE | TIMING_MODE_ENABLE, OK);
    wr(out_card_pkg::OFS_DATA, dw(SLOT, 12'h5A5), OK);
    step(20);
    `CHECK(gate, 1'b1)
    `CHECK(cflag, 1'b1)
    `CHECK(cflag_oe_n, 1'b0)
    `CHECK(irq, 1'b0)
    rd(out_card_pkg::OFS_STATUS, 32'h0000_FFF3, OK);
    mode <= 2'h1;
    for (n = 0; n < 30 && cflag; n++) step(1);
    step(2);
    `CHECK(cflag, 1'b0)
    `CHECK(gate, 1'b0)
    `CHECK(irq, 1'b1)
    `CHECK(srq, 1'b0)
    rd(out_card_pkg::OFS_INT_STATUS, 32'h0000_0001, OK);
    wr(out_card_pkg::OFS_INT_STATUS, 32'h0000_0001, OK);
    step(1);
    `CHECK(irq, 1'b0)
    wr(out_card_pkg::OFS_CONTROL, SYSTEM_OUTPUT_ENABLE | DATA_TRANSFER_ENABLE, OK);
    // Bus-link mode with the gate jumpered to the flag
    mode <= 2'h0;
    wr(out_card_pkg::OFS_CONFIG, cfg(3'h4), OK);
    wr(out_card_pkg::OFS_CONTROL, SYSTEM_OUTPUT_ENABLE | DATA_TRANSFER_ENABLE | TIMING_MODE_ENABLE, OK);
    wr(out_card_pkg::OFS_DATA, dw(SLOT, 12'h00F), OK);
    step(5);
    `CHECK(srq, 1'b1)
    `CHECK(irq, 1'b1)
    wr(out_card_pkg::OFS_INT_STATUS, 32'h0000_0001, OK);
    wr(out_card_pkg::OFS_CONTROL, SYSTEM_OUTPUT_ENABLE | DATA_TRANSFER_ENABLE, OK);
    step(1);
    `CHECK(srq, 1'b0)
    // Polarity option, then system enable off drives every line idle
    wr(out_card_pkg::OFS_CONFIG, cfg(3'h1), OK);
    wr(out_card_pkg::OFS_DATA, dw(SLOT, 12'h001), OK);
    step(2);
    `CHECK(data_line, 12'h001)
    for (n = 0; n < 30 && gate; n++) step(1);
    wr(out_card_pkg::OFS_CONTROL, 32'h0000_0000, OK);
    step(2);
    `CHECK(data_line, 12'h000)
    // Open-collector variant works with system enable off
    wr(out_card_pkg::OFS_CONFIG, cfg(3'h2), OK);
    wr(out_card_pkg::OFS_DATA, dw(SLOT, 12'h005), OK);
    step(2);
    `CHECK(oc_oe_n, 12'hFFA)
    `CHECK(oc_line, 12'h000)
    rd(out_card_pkg::OFS_STATUS, 32'h0000_FFA0, OK);
    wr(out_card_pkg::OFS_CONFIG, cfg(3'h3), OK);
    step(2);
    `CHECK(oc_oe_n, 12'h005)
    rd(out_card_pkg::OFS_CONTROL, 32'h0000_0000, OK);
    wr(8'h20, 32'h0000_0001, out_card_pkg::RESP_SLVERR);
    rd(8'h20, 32'h0000_0000, out_card_pkg::RESP_SLVERR);
    finish_test;
  end
endmodule
`default_nettype wire
